// file: rtl/scel_hyst.sv
// hysteresis comparator with separate set and clear levels
`timescale 1ns/1ns
`default_nettype none
module scel_hyst #(
	parameter int W = 8,
	parameter bit UP = 1'b1
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] value,
	input wire logic [W-1:0] set_level,
	input wire logic [W-1:0] clear_level,
	output logic flag
);
	// ---------------------------------------------
	// state
	// ---------------------------------------------
	typedef struct packed {
		logic flag; // current decision
	} scel_hyst_st_t;
	scel_hyst_st_t st_r; // registered state
	scel_hyst_st_t st_nxt; // next state
	// set when crossing set_level, clear when back past clear_level
	always_comb
	begin
		st_nxt = st_r;
		if (UP)
		begin
			if (value >= set_level)
				st_nxt.flag = 1'b1;
			else if (value <= clear_level)
				st_nxt.flag = 1'b0;
		end
		else
		begin
			if (value <= set_level)
				st_nxt.flag = 1'b1;
			else if (value >= clear_level)
				st_nxt.flag = 1'b0;
		end
	end
	// register
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
	assign flag = st_r.flag;
endmodule // scel_hyst
`default_nettype wire

// file: rtl/scel_pkg.sv
// package of constants and carrier types for the strap configuration and enable logic
package scel_pkg;
	// ---------------------------------------------
	// clock and timing
	// ---------------------------------------------
	localparam int unsigned CLK_HZ = 20_000_000; // ref_clk rate
	localparam int unsigned POR_TIMEOUT_US = 5500; // power-on timeout, typical, in us
	localparam int unsigned POR_TIMEOUT_MAX_US = 6500; // power-on timeout, worst case, in us
	localparam int unsigned POR_TIMEOUT_CYC = (CLK_HZ / 1000) * POR_TIMEOUT_US / 1000; // rounded down
	localparam int unsigned OC_RETRY_MS = 9; // overcurrent retry interval, in ms
	localparam int unsigned OC_RETRY_CYC = (CLK_HZ / 1000) * OC_RETRY_MS; // cycles per retry
	localparam int unsigned US_CLAMP_KHZ = 25; // ultrasonic light-load floor, in kHz
	localparam int unsigned US_CLAMP_CYC = CLK_HZ / (US_CLAMP_KHZ * 1000); // cycles per maximum pulse period
	localparam int unsigned CNT_W = 18; // width of the long timers
	// ---------------------------------------------
	// serial command codes
	// ---------------------------------------------
	localparam logic [7:0] CMD_OPERATION = 8'h01; // on/off operation command
	localparam logic [7:0] CMD_ON_OFF_CFG = 8'h02; // on/off configuration command
	localparam logic [7:0] CMD_BOOT_CODE = 8'hdc; // boot_voltage_pin_code read
	localparam logic [7:0] CMD_MODE_CODE = 8'hdd; // mode_comp_address_pin_code read
	localparam logic [7:0] CMD_FAULT_CODE = 8'hde; // fault_freq_gain_pin_code read
	localparam logic [7:0] CMD_RAMP_CODE = 8'hdf; // ramp_loop_pin_code read
	// ---------------------------------------------
	// field positions
	// ---------------------------------------------
	localparam int unsigned OPER_ON_BIT = 7; // operation: on bit
	localparam int unsigned CFG_CMD_BIT = 3; // on/off config: obey operation command
	localparam int unsigned CFG_PIN_BIT = 2; // on/off config: obey enable pin
	localparam int unsigned CFG_PU_BIT = 4; // on/off config: act on enable conditions at all
	localparam logic [7:0] OPERATION_RST = 8'h00; // operation reset value
	localparam logic [7:0] ON_OFF_CFG_RST = 8'h16; // on/off config reset value: pin only
	// ---------------------------------------------
	// fault thresholds
	// ---------------------------------------------
	localparam logic [7:0] OT_TRIP_CODE = 8'h72; // temperature code that trips shutdown
	localparam logic [7:0] OT_CLEAR_CODE = 8'h8e; // temperature code that clears shutdown
	localparam int unsigned OV_RISE_PCT = 120; // overvoltage rising level, percent of reference
	localparam int unsigned OV_FALL_PCT = 100; // overvoltage falling level, percent of reference
	// ---------------------------------------------
	// carriers
	// ---------------------------------------------
	// decoded second pin code
	typedef struct packed {
		logic pfm_enable; // light-load pulse-frequency mode
		logic [1:0] temp_comp_select; // temperature compensation offset
		logic [4:0] bus_address_select; // serial bus address index
	} scel_mode_t;
	// decoded third pin code
	typedef struct packed {
		logic ultrasonic_light_load_enable; // 25 kHz floor
		logic oc_retry; // 1: retry forever, 0: latch off
		logic [2:0] freq_select; // switching frequency index
		logic [2:0] error_amp_gain_select; // loop gain index
	} scel_fault_t;
	// decoded fourth pin code
	typedef struct packed {
		logic [2:0] ramp_rate_select; // soft-start and dynamic_voltage_change rate
		logic [1:0] ramp_resistor_select; // modulator ramp impedance
		logic gain_multiplier_select; // 1x or 2x
	} scel_ramp_t;
	// serial register request from the bus engine
	typedef struct packed {
		logic wr; // write strobe
		logic rd; // read strobe
		logic [7:0] cmd; // command code
		logic [7:0] wdata; // write byte
	} scel_req_t;
	// enable sequencing states, gray along the path
	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_WAIT = 2'b01,
		ST_READY = 2'b11,
		ST_ON = 2'b10
	} scel_state_t;
endpackage : scel_pkg

// file: rtl/scel_top.sv
// strap configuration loader, enable sequencing and fault decisions
`timescale 1ns/1ns
`default_nettype none
module scel_top
	import scel_pkg::*;
#(
	parameter int unsigned POR_CYC = scel_pkg::POR_TIMEOUT_CYC,
	parameter int unsigned RETRY_CYC = scel_pkg::OC_RETRY_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic input_supply_rail_ok,
	input wire logic high_bias_rail_ok,
	input wire logic driver_bias_rail_ok,
	input wire logic core_bias_rail_ok,
	input wire logic enable_pin,
	input wire logic [7:0] boot_voltage_pin,
	input wire logic [7:0] mode_comp_address_pin,
	input wire logic [7:0] fault_freq_gain_pin,
	input wire logic [7:0] ramp_loop_pin,
	input wire logic adc_valid,
	input wire logic [7:0] temp_code,
	input wire logic [11:0] vout_code,
	input wire logic [11:0] vref_code,
	input wire logic oc_event,
	input wire scel_pkg::scel_req_t bus_req,
	output logic bus_ack,
	output logic [7:0] bus_rdata,
	output logic bus_ready,
	output logic [7:0] boot_voltage_code,
	output scel_pkg::scel_mode_t mode_cfg,
	output scel_pkg::scel_fault_t fault_cfg,
	output scel_pkg::scel_ramp_t ramp_cfg,
	output logic regulator_on,
	output logic ot_shutdown,
	output logic ov_flag,
	output logic oc_latched,
	output logic us_floor_tick
);
	import scel_pkg::*;

	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	// percentage of a reference, widened to avoid overflow
	function automatic logic [13:0] pct_of(input logic [11:0] ref_v, input int unsigned pct);
		logic [20:0] prod;
		prod = 21'(ref_v) * 21'(pct);
		return 14'(prod / 21'd100);
	endfunction
	// limits a user must know:
	// codes are taken once per reset, later strap changes are ignored
	// requests before the timeout ends get no answer at all
	// overvoltage only raises its flag, it never stops the regulator

	// ---------------------------------------------
	// state
	// ---------------------------------------------
	// block state apart from the two comparator flags in u_ot and u_ov, registered in one place
	typedef struct packed {
		scel_state_t state; // enable sequence
		logic [CNT_W-1:0] por_cnt; // power-on timeout counter
		logic [CNT_W-1:0] retry_cnt; // overcurrent retry counter
		logic [9:0] us_cnt; // ultrasonic floor divider
		logic loaded; // codes captured
		logic [7:0] code1; // boot_voltage_pin_code
		logic [7:0] code2; // mode_comp_address_pin_code
		logic [7:0] code3; // fault_freq_gain_pin_code
		logic [7:0] code4; // ramp_loop_pin_code
		logic [7:0] operation; // operation byte
		logic [7:0] on_off_cfg; // on/off configuration byte
		logic oc_latch; // overcurrent latched off
		logic oc_wait; // waiting out a retry interval
		logic ack; // bus answer strobe
		logic [7:0] rdata; // bus read data
		logic on; // regulator enabled
		logic ready; // bus answering
		logic ot; // registered over-temperature
		logic ov; // registered overvoltage
		logic tick; // ultrasonic floor tick
	} scel_st_t;
	scel_st_t st_r; // registered state
	scel_st_t st_nxt; // next state

	// ---------------------------------------------
	// internal signals
	// ---------------------------------------------
	logic rails_ok; // input supply and all three bias rails good, enable_pin not included
	logic ot_raw; // over-temperature comparator
	logic ov_raw; // overvoltage comparator
	logic [13:0] ov_rise; // overvoltage rising level
	logic [13:0] ov_fall; // overvoltage falling level
	logic [13:0] vout_w; // widened output reading
	logic want_on; // enable request after config
	logic cmd_on; // operation command says on
	logic [7:0] temp_in; // temperature value into comparator

	// ---------------------------------------------
	// rail gate and comparator inputs
	// ---------------------------------------------
	assign rails_ok = input_supply_rail_ok & high_bias_rail_ok & driver_bias_rail_ok
		& core_bias_rail_ok;
	assign ov_rise = pct_of(vref_code, OV_RISE_PCT);
	assign ov_fall = pct_of(vref_code, OV_FALL_PCT);
	assign vout_w = 14'(vout_code);
	// no reading counts as cool, so no false trip
	assign temp_in = adc_valid ? temp_code : OT_CLEAR_CODE;

	// ---------------------------------------------
	// fault comparators
	// ---------------------------------------------
	// temperature code falls as it heats: trip at or below 72h, clear at 8Eh
	scel_hyst #(
		.W(8),
		.UP(1'b0)
	) u_ot (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.value(temp_in),
		.set_level(OT_TRIP_CODE),
		.clear_level(OT_CLEAR_CODE),
		.flag(ot_raw)
	);
	// output at or over 120 percent sets, back to 100 percent clears
	// 14 bits so 120 percent of full scale still fits
	scel_hyst #(
		.W(14),
		.UP(1'b1)
	) u_ov (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.value(vout_w),
		.set_level(ov_rise),
		.clear_level(ov_fall),
		.flag(ov_raw)
	);

	// ---------------------------------------------
	// next state
	// ---------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		// strobes default low each cycle
		st_nxt.ack = 1'b0;
		st_nxt.tick = 1'b0;
		// fault levels follow their comparators
		st_nxt.ot = ot_raw;
		st_nxt.ov = ov_raw;
		// enable source selection from on/off config
		cmd_on = st_r.operation[OPER_ON_BIT];
		// bit 4 low: enable conditions ignored
		if (!st_r.on_off_cfg[CFG_PU_BIT])
			want_on = 1'b1; // always on once powered
		else
			want_on = (!st_r.on_off_cfg[CFG_CMD_BIT] || cmd_on)
				&& (!st_r.on_off_cfg[CFG_PIN_BIT] || enable_pin);
		// sequencing
		// off, wait, ready, on; any rail loss back to off
		unique case (st_r.state)
			ST_OFF:
			begin
				// rails low: hold timer clear
				st_nxt.por_cnt = '0;
				if (rails_ok)
					st_nxt.state = ST_WAIT;
			end
			ST_WAIT:
			begin
				// count out the power-on timeout
				if (!rails_ok)
					st_nxt.state = ST_OFF;
				else if (st_r.por_cnt >= CNT_W'(POR_CYC - 1))
					st_nxt.state = ST_READY;
				else
					st_nxt.por_cnt = st_r.por_cnt + 1'b1;
			end
			ST_READY:
			begin
				// bus live, regulator waits for request
				if (!rails_ok)
					st_nxt.state = ST_OFF;
				else if (want_on && !st_r.oc_latch && !st_r.oc_wait && !ot_raw)
					st_nxt.state = ST_ON;
			end
			ST_ON:
			begin
				// running until a fault or request drop
				if (!rails_ok)
					st_nxt.state = ST_OFF;
				else if (!want_on || ot_raw || oc_event)
					st_nxt.state = ST_READY;
			end
		endcase
		// capture codes once on first pass of the timeout
		if (st_r.state == ST_WAIT && !st_r.loaded)
		begin
			st_nxt.loaded = 1'b1;
			st_nxt.code1 = boot_voltage_pin;
			st_nxt.code2 = mode_comp_address_pin;
			st_nxt.code3 = fault_freq_gain_pin;
			st_nxt.code4 = ramp_loop_pin;
		end
		// overcurrent response: latch or timed retry
		if (st_r.state == ST_ON && oc_event)
		begin
			// third code bit 6: retry or latch
			if (st_r.code3[6])
			begin
				st_nxt.oc_wait = 1'b1;
				st_nxt.retry_cnt = '0;
			end
			else
				st_nxt.oc_latch = 1'b1;
		end
		else if (st_r.oc_wait)
		begin
			// count out the retry interval
			if (st_r.retry_cnt >= CNT_W'(RETRY_CYC - 1))
				st_nxt.oc_wait = 1'b0;
			else
				st_nxt.retry_cnt = st_r.retry_cnt + 1'b1;
		end
		// latched overcurrent cleared by toggling the request
		if (st_r.oc_latch && !want_on)
			st_nxt.oc_latch = 1'b0;
		// ultrasonic floor divider runs while on in that mode
		if (st_r.on && st_r.code3[7])
		begin
			if (st_r.us_cnt >= 10'(US_CLAMP_CYC - 1))
			begin
				st_nxt.us_cnt = '0;
				st_nxt.tick = 1'b1;
			end
			else
				st_nxt.us_cnt = st_r.us_cnt + 1'b1;
		end
		else
			// divider held clear when not needed
			st_nxt.us_cnt = '0;
		// serial register access, only once the timeout is over
		if ((st_r.state == ST_READY || st_r.state == ST_ON) && (bus_req.rd || bus_req.wr))
		begin
			st_nxt.ack = 1'b1;
			// read data zero unless a read hits
			st_nxt.rdata = 8'h00;
			if (bus_req.wr)
			begin
				// writes land only in the two control bytes
				if (bus_req.cmd == CMD_OPERATION)
					st_nxt.operation = bus_req.wdata;
				else if (bus_req.cmd == CMD_ON_OFF_CFG)
					st_nxt.on_off_cfg = bus_req.wdata;
			end
			else
			begin
				// reads pick a byte by command code
				unique case (bus_req.cmd)
					CMD_OPERATION: st_nxt.rdata = st_r.operation;
					CMD_ON_OFF_CFG: st_nxt.rdata = st_r.on_off_cfg;
					CMD_BOOT_CODE: st_nxt.rdata = st_r.code1;
					CMD_MODE_CODE: st_nxt.rdata = st_r.code2;
					CMD_FAULT_CODE: st_nxt.rdata = st_r.code3;
					CMD_RAMP_CODE: st_nxt.rdata = st_r.code4;
					default: st_nxt.rdata = 8'h00; // unmapped reads zero
				endcase
			end
		end
		// output levels track the next state
		st_nxt.on = (st_nxt.state == ST_ON);
		st_nxt.ready = (st_nxt.state == ST_READY) || (st_nxt.state == ST_ON);
	end

	// ---------------------------------------------
	// register
	// ---------------------------------------------
	// asynchronous clear, then one copy per clock
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// control bytes take their own reset values
			st_r <= '0;
			st_r.operation <= OPERATION_RST;
			st_r.on_off_cfg <= ON_OFF_CFG_RST;
		end
		else
			st_r <= st_nxt;
	end

	// ---------------------------------------------
	// outputs, all from flip-flops
	// ---------------------------------------------
	// bus answer
	assign bus_ack = st_r.ack;
	assign bus_rdata = st_r.rdata;
	assign bus_ready = st_r.ready;
	// captured codes and their fields
	assign boot_voltage_code = st_r.code1;
	assign mode_cfg = '{
		pfm_enable: st_r.code2[7],
		temp_comp_select: st_r.code2[6:5],
		bus_address_select: st_r.code2[4:0]
	};
	assign fault_cfg = '{
		ultrasonic_light_load_enable: st_r.code3[7],
		oc_retry: st_r.code3[6],
		freq_select: st_r.code3[5:3],
		error_amp_gain_select: st_r.code3[2:0]
	};
	assign ramp_cfg = '{
		ramp_rate_select: st_r.code4[7:5],
		ramp_resistor_select: st_r.code4[4:3],
		gain_multiplier_select: st_r.code4[2]
	};
	// sequencing and fault levels
	assign regulator_on = st_r.on;
	assign ot_shutdown = st_r.ot;
	assign ov_flag = st_r.ov;
	assign oc_latched = st_r.oc_latch;
	assign us_floor_tick = st_r.tick;
endmodule // scel_top
`default_nettype wire

// file: sim/scel_host_model.sv
// divider codes and serial host in front of scel_top
`timescale 1ns/1ns
`default_nettype none
module scel_host_model
	import scel_pkg::*;
(
	input wire logic ref_clk,
	input wire logic bus_ack,
	input wire logic [7:0] bus_rdata,
	input wire logic bus_ready,
	output logic [7:0] boot_voltage_pin,
	output logic [7:0] mode_comp_address_pin,
	output logic [7:0] fault_freq_gain_pin,
	output logic [7:0] ramp_loop_pin,
	output scel_pkg::scel_req_t bus_req
);
	logic [7:0] strap [4]; // divider codes, set by the bench
	assign boot_voltage_pin = strap[0];
	assign mode_comp_address_pin = strap[1];
	assign fault_freq_gain_pin = strap[2];
	assign ramp_loop_pin = strap[3];
	initial bus_req = '{wr: 1'b0, rd: 1'b0, cmd: 8'ha5, wdata: 8'h5a};
	// host holds off until the device may answer
	task automatic wait_ready(output bit ok);
		ok = 1'b0;
		for (int i = 0; i < 200 && !ok; i++)
		begin
			@(posedge ref_clk);
			#5;
			ok = bus_ready;
		end
	endtask
	// one byte transfer; strobe for one cycle, then idle lines flip
	task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [7:0] wd,
		output logic [7:0] rdata, output bit acked);
		acked = 1'b0;
		rdata = 8'h00;
		@(posedge ref_clk);
		#5;
		bus_req = '{wr: wr, rd: !wr, cmd: cmd, wdata: wd};
		@(posedge ref_clk);
		#5;
		bus_req = '{wr: 1'b0, rd: 1'b0, cmd: ~cmd, wdata: ~wd};
		for (int i = 0; i < 3 && !acked; i++)
		begin
			acked = bus_ack;
			rdata = bus_rdata;
			if (!acked)
			begin
				@(posedge ref_clk);
				#5;
			end
		end
	endtask
endmodule // scel_host_model
`default_nettype wire

// file: sim/scel_top_props.sv
// assertion checker for scel_top
`timescale 1ns/1ns
`default_nettype none
module scel_top_props
	import scel_pkg::*;
#(
	parameter int unsigned POR_CYC = scel_pkg::POR_TIMEOUT_CYC,
	parameter int unsigned RETRY_CYC = scel_pkg::OC_RETRY_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic input_supply_rail_ok,
	input wire logic high_bias_rail_ok,
	input wire logic driver_bias_rail_ok,
	input wire logic core_bias_rail_ok,
	input wire logic adc_valid,
	input wire logic [7:0] temp_code,
	input wire logic [11:0] vout_code,
	input wire logic [11:0] vref_code,
	input wire scel_pkg::scel_req_t bus_req,
	input wire logic bus_ack,
	input wire logic [7:0] bus_rdata,
	input wire logic bus_ready,
	input wire logic [7:0] boot_voltage_code,
	input wire scel_pkg::scel_mode_t mode_cfg,
	input wire scel_pkg::scel_fault_t fault_cfg,
	input wire scel_pkg::scel_ramp_t ramp_cfg,
	input wire logic regulator_on,
	input wire logic ot_shutdown,
	input wire logic ov_flag,
	input wire logic oc_latched,
	input wire logic us_floor_tick
);
	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	logic rails_ok; // input supply and all bias rails up
	logic [31:0] ok_cnt_r; // cycles with all rails up
	logic seen_r; // bus has been ready since reset
	assign rails_ok = input_supply_rail_ok & high_bias_rail_ok & driver_bias_rail_ok & core_bias_rail_ok;
	// counts rail-good time, remembers first readiness
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ok_cnt_r <= 32'h0;
			seen_r <= 1'b0;
		end
		else
		begin
			ok_cnt_r <= rails_ok ? ok_cnt_r + 32'h1 : 32'h0;
			seen_r <= seen_r | bus_ready;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ---------------------------------------------
	// properties
	// ---------------------------------------------
	ack_cause_a: assert property (bus_ack |-> $past(bus_ready & (bus_req.rd | bus_req.wr)))
		else $error("ack without a taken request");
	ack_due_a: assert property (bus_ready & (bus_req.rd | bus_req.wr) |=> bus_ack)
		else $error("taken request not acked");
	rd_boot_a: assert property (bus_ready & bus_req.rd & !bus_req.wr & (bus_req.cmd == CMD_BOOT_CODE)
		|=> bus_rdata == boot_voltage_code) else $error("boot code read wrong");
	rd_fault_a: assert property (bus_ready & bus_req.rd & !bus_req.wr & (bus_req.cmd == CMD_FAULT_CODE)
		|=> bus_rdata == fault_cfg) else $error("fault code read wrong");
	ready_late_a: assert property (bus_ready |-> ok_cnt_r >= POR_CYC)
		else $error("bus ready before timeout");
	on_late_a: assert property ($rose(regulator_on) |-> ok_cnt_r > POR_CYC)
		else $error("enabled before timeout");
	rail_drop_a: assert property (!rails_ok |-> ##2 !regulator_on)
		else $error("still on after rail drop");
	ot_trip_a: assert property ((adc_valid & (temp_code <= OT_TRIP_CODE)) [*2] |=> ot_shutdown)
		else $error("hot reading did not trip");
	ot_clear_a: assert property ($fell(ot_shutdown) |-> $past(!adc_valid | (temp_code >= OT_CLEAR_CODE), 2))
		else $error("shutdown cleared too early");
	ot_stop_a: assert property (ot_shutdown [*3] |-> !regulator_on)
		else $error("on during shutdown");
	ov_set_a: assert property ($rose(ov_flag) |-> $past(32'(vout_code) * 5 >= 32'(vref_code) * 6, 2))
		else $error("overvoltage set below level");
	oc_off_a: assert property (oc_latched [*2] |-> !regulator_on)
		else $error("on while latched off");
	codes_hold_a: assert property (seen_r |-> $stable({boot_voltage_code, mode_cfg, fault_cfg, ramp_cfg}))
		else $error("codes changed after capture");
	tick_gate_a: assert property (us_floor_tick |->
		fault_cfg.ultrasonic_light_load_enable ##1 !us_floor_tick [*8]) else $error("floor tick misplaced");
	on_c: cover property ($rose(regulator_on));
	ot_c: cover property ($rose(ot_shutdown));
	tick_c: cover property (us_floor_tick);
endmodule // scel_top_props
bind scel_top scel_top_props #(.POR_CYC(POR_CYC), .RETRY_CYC(RETRY_CYC)) i_scel_top_props (.ref_clk, .rst_n,
	.input_supply_rail_ok, .high_bias_rail_ok, .driver_bias_rail_ok, .core_bias_rail_ok, .adc_valid, .temp_code,
	.vout_code, .vref_code, .bus_req, .bus_ack, .bus_rdata, .bus_ready, .boot_voltage_code, .mode_cfg, .fault_cfg,
	.ramp_cfg, .regulator_on, .ot_shutdown, .ov_flag, .oc_latched, .us_floor_tick);
`default_nettype wire

// file: sim/tb_scel_top.sv
// self-checking bench for scel_top
`timescale 1ns/1ns
`default_nettype none
module tb_scel_top;
	import scel_pkg::*;
	localparam int unsigned POR = 20; // shortened power-on timeout
	localparam int unsigned RTY = 30; // shortened retry wait
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic input_supply_rail_ok, high_bias_rail_ok, driver_bias_rail_ok, core_bias_rail_ok;
	logic enable_pin, adc_valid, oc_event, bus_ack, bus_ready, regulator_on, ot_shutdown, ov_flag, oc_latched;
	logic us_floor_tick;
	logic [7:0] temp_code, bus_rdata, boot_voltage_code, d;
	logic [7:0] boot_voltage_pin, mode_comp_address_pin, fault_freq_gain_pin, ramp_loop_pin;
	logic [11:0] vout_code, vref_code;
	scel_req_t bus_req;
	scel_mode_t mode_cfg;
	scel_fault_t fault_cfg;
	scel_ramp_t ramp_cfg;
	bit ok;
	int n;
	int err_count = 0;
	int check_count = 0;
	always #25 ref_clk = ~ref_clk;
	scel_top #(.POR_CYC(POR), .RETRY_CYC(RTY)) i_scel_top (.ref_clk, .rst_n, .input_supply_rail_ok,
		.high_bias_rail_ok, .driver_bias_rail_ok, .core_bias_rail_ok, .enable_pin, .boot_voltage_pin,
		.mode_comp_address_pin, .fault_freq_gain_pin, .ramp_loop_pin, .adc_valid, .temp_code, .vout_code,
		.vref_code, .oc_event, .bus_req, .bus_ack, .bus_rdata, .bus_ready, .boot_voltage_code, .mode_cfg,
		.fault_cfg, .ramp_cfg, .regulator_on, .ot_shutdown, .ov_flag, .oc_latched, .us_floor_tick);
	scel_host_model i_scel_host_model (.ref_clk, .bus_ack, .bus_rdata, .bus_ready, .boot_voltage_pin,
		.mode_comp_address_pin, .fault_freq_gain_pin, .ramp_loop_pin, .bus_req);
	// counts and verdict, then stop
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// k edges, then settle past the edge
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
		#5;
	endtask
	// bounded wait for the regulator level; cnt is cycles taken
	task automatic wait_reg(input logic want, input int lim, output int cnt);
		for (cnt = 0; regulator_on !== want; cnt++)
		begin
			if (cnt == lim)
			begin
				chk(regulator_on, want);
				end_of_test();
			end
			cyc(1);
		end
		check_count++;
	endtask
	task automatic rd(input logic [7:0] cmd, output logic [7:0] v);
		i_scel_host_model.xfer(1'b0, cmd, 8'h00, v, ok);
		chk(ok, 1);
	endtask
	task automatic wr(input logic [7:0] cmd, input logic [7:0] v);
		i_scel_host_model.xfer(1'b1, cmd, v, d, ok);
		chk(ok, 1);
	endtask
	task automatic do_reset();
		rst_n = 1'b0;
		cyc(6);
		rst_n = 1'b1;
	endtask
	// early access refused, enable only after timeout
	task automatic t_power_up();
		i_scel_host_model.xfer(1'b0, CMD_BOOT_CODE, 8'h00, d, ok);
		chk(ok, 0);
		chk(regulator_on, 0);
		i_scel_host_model.wait_ready(ok);
		chk(ok, 1);
		wait_reg(1'b1, 8, n);
	endtask
	// readback, decode, read-only, unmapped, hold
	task automatic t_codes();
		logic [7:0] s [4];
		logic [7:0] m;
		s = i_scel_host_model.strap;
		for (int k = 0; k < 4; k++)
		begin
			m = (k == 3) ? 8'hfc : 8'hff;
			rd(CMD_BOOT_CODE + 8'(k), d);
			chk(d & m, s[k] & m);
		end
		chk(boot_voltage_code, s[0]);
		chk(mode_cfg, s[1]);
		chk(fault_cfg, s[2]);
		chk(ramp_cfg, s[3][7:2]);
		wr(CMD_BOOT_CODE, ~s[0]);
		rd(CMD_BOOT_CODE, d);
		chk(d, s[0]);
		rd(8'h7e, d);
		chk(d, 8'h00);
		for (int k = 0; k < 4; k++)
			i_scel_host_model.strap[k] = ~s[k];
		cyc(5);
		chk({boot_voltage_code, mode_cfg, fault_cfg, ramp_cfg}, {s[0], s[1], s[2], s[3][7:2]});
		i_scel_host_model.strap = s;
	endtask
	// command only, both, pin only
	task automatic t_onoff();
		enable_pin = 1'b0;
		wait_reg(1'b0, 4, n);
		wr(CMD_ON_OFF_CFG, 8'h1a);
		cyc(4);
		chk(regulator_on, 0);
		wr(CMD_OPERATION, 8'h80);
		wait_reg(1'b1, 4, n);
		wr(CMD_ON_OFF_CFG, 8'h1e);
		wait_reg(1'b0, 4, n);
		enable_pin = 1'b1;
		wait_reg(1'b1, 4, n);
		wr(CMD_OPERATION, 8'h00);
		wait_reg(1'b0, 4, n);
		wr(CMD_ON_OFF_CFG, 8'h16);
		wait_reg(1'b1, 4, n);
		enable_pin = 1'b0;
		wait_reg(1'b0, 4, n);
		wr(CMD_ON_OFF_CFG, 8'h0e);
		wait_reg(1'b1, 4, n);
		wr(CMD_ON_OFF_CFG, 8'h16);
		enable_pin = 1'b1;
		cyc(2);
		chk(regulator_on, 1);
	endtask
	// temperature and overvoltage hysteresis at the exact codes
	task automatic t_faults();
		adc_valid = 1'b1;
		temp_code = OT_TRIP_CODE;
		cyc(3);
		chk(ot_shutdown, 1);
		wait_reg(1'b0, 4, n);
		temp_code = OT_CLEAR_CODE - 8'h01;
		cyc(3);
		chk(ot_shutdown, 1);
		temp_code = OT_CLEAR_CODE;
		wait_reg(1'b1, 6, n);
		vout_code = 12'h4b0;
		cyc(3);
		chk(ov_flag, 1);
		vout_code = 12'h3e9;
		cyc(3);
		chk(ov_flag, 1);
		vout_code = 12'h3e8;
		cyc(3);
		chk(ov_flag, 0);
	endtask
	// latch-off overcurrent, cleared by enable; then rail drop
	task automatic t_oc_latch();
		oc_event = 1'b1;
		cyc(1);
		oc_event = 1'b0;
		wait_reg(1'b0, 4, n);
		cyc(RTY + 10);
		chk({oc_latched, regulator_on}, 2'b10);
		enable_pin = 1'b0;
		cyc(3);
		chk(oc_latched, 0);
		enable_pin = 1'b1;
		wait_reg(1'b1, 4, n);
		core_bias_rail_ok = 1'b0;
		wait_reg(1'b0, 3, n);
		chk(bus_ready, 0);
		core_bias_rail_ok = 1'b1;
		wait_reg(1'b1, POR + 10, n);
	endtask
	// new straps after reset, floor tick spacing, timed retry
	task automatic t_retry_tick();
		i_scel_host_model.strap[2] = 8'hc9;
		do_reset();
		wait_reg(1'b1, POR + 10, n);
		chk(fault_cfg, 8'hc9);
		for (int k = 0; k < 900 && us_floor_tick !== 1'b1; k++)
			cyc(1);
		n = 0;
		do
		begin
			cyc(1);
			n++;
		end
		while (us_floor_tick !== 1'b1 && n < 900);
		chk(n, US_CLAMP_CYC);
		oc_event = 1'b1;
		cyc(1);
		oc_event = 1'b0;
		wait_reg(1'b0, 4, n);
		wait_reg(1'b1, RTY + 10, n);
		chk(n + 4 >= RTY && oc_latched === 1'b0, 1);
	endtask
	initial
	begin
		{input_supply_rail_ok, high_bias_rail_ok, driver_bias_rail_ok, core_bias_rail_ok} = 4'hf;
		enable_pin = 1'b1;
		adc_valid = 1'b0;
		oc_event = 1'b0;
		temp_code = 8'hff;
		vout_code = 12'h3e8;
		vref_code = 12'h3e8;
		i_scel_host_model.strap = '{8'h9f, 8'h5f, 8'h2d, 8'hb7};
		do_reset();
		t_power_up();
		t_codes();
		t_onoff();
		t_faults();
		t_oc_latch();
		t_retry_tick();
		end_of_test();
	end
endmodule // tb_scel_top
`default_nettype wire
